// [sim/boot_id_auth_and_baud_cmds_tb.sv]
// self-checking bench of the key check and bit rate handler
`timescale 1ns/1ps
module boot_id_auth_and_baud_cmds_tb;
  import boot_cmd_pkg::*;
  logic         clock, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic         rx_valid, tx_valid, tx_ready, erase_start, erase_done;
  logic         erase_fault, program_fault, sequencer_fault;
  logic         access_window_lock_bit, modulation_enable;
  logic         half_oversample_select, command_phase;
  logic [1:0]   prescale_select;
  logic [4:0]   avs_address;
  logic [7:0]   rx_data, tx_data, bit_rate_divisor, modulation_duty, er_cnt;
  logic [17:0]  exp_set;
  logic [19:0]  uart_set;
  logic [31:0]  avs_writedata, avs_readdata, rd;
  logic [127:0] stored_id, rid, hid[2];
  int           seed = 32'h259C;
  int           num_errors = 0, checked = 0, cyc = 0, n_erase = 0;
  boot_cmd_handler uut (.clock, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .rx_valid,
    .rx_data, .tx_valid, .tx_data, .tx_ready, .stored_id,
    .access_window_lock_bit, .erase_start, .erase_done, .erase_fault,
    .program_fault, .sequencer_fault, .bit_rate_divisor, .modulation_duty,
    .modulation_enable, .half_oversample_select, .prescale_select,
    .command_phase);
  prog_model pm (.clock, .sys_rst, .rx_valid, .rx_data, .tx_valid,
    .tx_data, .tx_ready);
  assign uart_set = {bit_rate_divisor, modulation_duty, modulation_enable,
                     half_oversample_select, prescale_select};
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // eraser answers twenty cycles after each start
  always @(posedge clock)
    if (sys_rst)
      er_cnt <= 8'h00;
    else if (erase_start)
    begin
      er_cnt <= 8'h14;
      n_erase <= n_erase + 1;
    end
    else if (er_cnt != 8'h00)
      er_cnt <= er_cnt - 8'h01;
  assign erase_done = er_cnt == 8'h01;
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic reply(input logic [7:0] c, s);
    logic [7:0] e[7];
    e = '{REPLY_LEAD, LEN_HIGH, LEN_REPLY, c, s, 8'h00 - LEN_REPLY - c - s,
          TRAILER};
    for (int i = 0; i < 2000 && pm.rq.size() < 7; i++)
      @(posedge clock);
    cmp(pm.rq.size(), 7);
    while (pm.rq.size() < 7)
      pm.rq.push_back(8'hXX);
    foreach (e[i])
      cmp(pm.rq[i], e[i]);
    pm.rq.delete();
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    pm.rq.delete();
    exp_set = {8'hFF, 8'hFF, 2'b00};
  endtask
  // status, divisor, duty, modulation enable, half oversample
  function automatic logic [25:0] calc(input longint r,
                                       input logic [7:0] od);
    longint c, b, d, m, a;
    c = CLOCK_HZ_RESET;
    if (r == 0 || r > LIMIT_RESET)
      return {ST_MARGIN, 18'h0};
    d = (c / r < 32) ? 0 : c / r / 32 - 1;
    d = (d > 255) ? 255 : d;
    b = (c / r < 32) ? c / 16 : c / ((d + 1) * 32);
    m = 256 * r / b;
    a = (m > 255) ? b : b * ((m < 128) ? 128 : m) / 256;
    if (((a > r) ? a - r : r - a) * 25 > r)
      return {ST_MARGIN, 18'h0};
    return {ST_OK, d[7:0], (m > 255) ? od : ((m < 128) ? 8'h80 : m[7:0]),
            m <= 255, c / r < 32};
  endfunction
  task automatic rate_cmd(input logic [31:0] r, input logic auth);
    logic [25:0] e;
    e = auth ? {ST_FLOW, exp_set} : calc(r, exp_set[9:2]);
    pm.send(OP_RATE, LEN_RATE, {r, 96'h0}, 4, 2'b00);
    reply((e[25:18] == ST_OK) ? OP_RATE : REPLY_RATE_ERR, e[25:18]);
    if (e[25:18] == ST_OK)
      exp_set = e[17:0];
    cmp(uart_set, {exp_set, 2'b00});
  endtask
  initial
  begin
    logic [4:0]  ra[5];
    logic [31:0] rv[5];
    logic [2:0]  fl[5];
    logic [7:0]  est[5];
    logic [31:0] rt[6];
    ra = '{REG_STATUS, REG_RATE, REG_CLOCK, REG_LIMIT, 5'h14};
    rv = '{32'h0, 32'h0000_FFFF, 32'h02FA_F080, 32'h001E_8480, 32'h0};
    fl = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h0};
    est = '{ST_PROTECT, ST_ERASE, ST_WRITE, ST_SEQUENCER, ST_OK};
    rt = '{32'h0, 32'h2580, 32'h1_C200, 32'h1E_8480, 32'h1E_8481, 32'h16_E360};
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {erase_fault, program_fault, sequencer_fault} = 3'h0;
    {sys_rst, access_window_lock_bit} = 2'b10;
    rid = {$random(seed), $random(seed), $random(seed), $random(seed)};
    stored_id = {2'b10, rid[125:0]};
    do_reset();
    bus(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 32'h0);
      cmp(rd, rv[i]);
    end
    bus(1'b1, REG_LIMIT, 32'h0012_3456);
    bus(1'b0, REG_LIMIT, 32'h0);
    cmp(rd, 32'h0012_3456);
    rate_cmd(32'h0001_C200, 1'b1);
    pm.send(OP_KEY, LEN_KEY, stored_id, 16, 2'b11);
    reply(REPLY_KEY_ERR, ST_PACKET);
    pm.send(OP_KEY, LEN_KEY, stored_id, 16, 2'b01);
    reply(REPLY_KEY_ERR, ST_CHECKSUM);
    pm.send(OP_KEY, 8'h10, stored_id, 15, 2'b00);
    reply(REPLY_KEY_ERR, ST_PACKET);
    pm.send(OP_KEY, LEN_KEY, stored_id, 16, 2'b00);
    reply(OP_KEY, ST_OK);
    cmp(command_phase, 1'b1);
    hid = '{{1'b0, rid[126:0]}, {2'b10, rid[125:0]}};
    foreach (hid[i])
    begin
      stored_id <= hid[i];
      do_reset();
      pm.send(OP_KEY, LEN_KEY, MASS_ERASE_KEY, 16, 2'b00);
      reply(REPLY_KEY_ERR, i ? ST_MISMATCH : ST_DISABLE);
      pm.send(OP_KEY, LEN_KEY, hid[i], 16, 2'b00);
      repeat (400) @(posedge clock);
      cmp(pm.rq.size(), 0);
      bus(1'b0, REG_STATUS, 32'h0);
      cmp(rd, 32'h0000_0020);
      bus(1'b0, REG_OUTCOME, 32'h0);
      cmp(rd, {16'h0, REPLY_KEY_ERR, i ? ST_MISMATCH : ST_DISABLE});
    end
    stored_id <= {2'b11, rid[125:0]};
    do_reset();
    for (int i = 0; i < 5; i++)
    begin
      {erase_fault, program_fault, sequencer_fault} <= fl[i];
      access_window_lock_bit <= i > 0;
      pm.send(OP_KEY, LEN_KEY, MASS_ERASE_KEY, 16, 2'b00);
      reply((i < 4) ? REPLY_KEY_ERR : OP_KEY, est[i]);
      cmp(n_erase, i);
      cmp(command_phase, i == 4);
    end
    pm.send(OP_KEY, LEN_KEY, stored_id, 16, 2'b00);
    reply(REPLY_KEY_ERR, ST_FLOW);
    pm.send(OP_KEY, LEN_KEY, stored_id, 16, 2'b01);
    reply(REPLY_KEY_ERR, ST_CHECKSUM);
    foreach (rt[i])
      rate_cmd(rt[i], 1'b0);
    repeat (8) rate_cmd($random(seed) & 32'h001F_FFFF, 1'b0);
    wrap_up();
  end
endmodule

// [sim/prog_model.sv]
// programmer model: sends command frames and collects reply bytes
`timescale 1ns/1ps
module prog_model
  import boot_cmd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] rq[$];
  logic [1:0] st_cnt;
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h5A;
  end
  // stalls the reply two cycles in four
  always @(posedge clock or posedge sys_rst)
    if (sys_rst)
      st_cnt <= 2'h0;
    else
      st_cnt <= st_cnt + 2'h1;
  assign tx_ready = st_cnt[1];
  always @(posedge clock)
    if (tx_valid && tx_ready)
      rq.push_back(tx_data);
  // f[0] spoils the check byte, f[1] sends 00 in place of the trailer
  task automatic send(input logic [7:0] op, ln, input logic [127:0] b,
                      input int n, input logic [1:0] f);
    logic [7:0] q[$];
    logic [7:0] s;
    q = {CMD_LEAD, LEN_HIGH, ln, op};
    for (int i = 0; i < n; i++)
      q.push_back(b[127-8*i -: 8]);
    s = 8'h00;
    for (int i = 1; i < q.size(); i++)
      s = s + q[i];
    q.push_back((8'h00 - s) ^ {8{f[0]}});
    q.push_back(f[1] ? 8'h00 : TRAILER);
    foreach (q[i])
    begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data <= q[i];
      @(posedge clock);
      rx_valid <= 1'b0;
      rx_data <= ~q[i];
    end
  endtask
endmodule

// [src/boot_cmd_handler.sv]
// key check and bit rate command handler of the boot responder
// Operation
// - key check runs only in authentication phase, else flow error C3
// - first key byte lands on stored id bits 127:120, last on 7:0
// - stored id bit 127 zero: disable error DC, then hang for good
// - id bits 127:126 equal 10b: always compare, mass erase key ignored
// - id bits 11b with mass erase key: erase all, enter command phase
// - mass erase key is 41 4C 65 52 41 53 45 then nine FF bytes
// - key mismatch gives DB and hang; match gives OK and command phase
// - success reply is 81 00 02 30 00 CE 03
// - key check failure reply uses code B0 with one status code
// - mass erase with access window lock bit zero: protection error DA
// - erase failures report E1, write E2, sequencer E7
// - error priority: trailer C1, then checksum C2, length C1, phase
// - bit rate command only in command phase, else flow error C3
// - a failed bit rate command leaves the uart settings untouched
// - margin error D4 for deviation over 4%, zero rate or over limit
// - bit rate accepted: code 34, status 00, sum CA; rejected: B4
// - ratio below 32: half oversample, divisor 0; else ratio/32-1 sat
// - prescale select is always 00b
// - duty is 256*rate/base; overflow disables, below 128 gives 80h
// - bit rate command touches only the uart settings
// - limit is the recommended maximum uart rate in bits per second
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module boot_cmd_handler
  import boot_cmd_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic [4:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_data,
  output logic               tx_valid,
  output logic      [7:0]    tx_data,
  input  wire logic          tx_ready,
  input  wire logic [127:0]  stored_id,
  input  wire logic          access_window_lock_bit,
  output logic               erase_start,
  input  wire logic          erase_done,
  input  wire logic          erase_fault,
  input  wire logic          program_fault,
  input  wire logic          sequencer_fault,
  output logic      [7:0]    bit_rate_divisor,
  output logic      [7:0]    modulation_duty,
  output logic               modulation_enable,
  output logic               half_oversample_select,
  output logic      [1:0]    prescale_select,
  output logic               command_phase
);

  typedef enum logic [3:0] {
    st_lead, st_lenh, st_lenl, st_body, st_sum, st_trail,
    st_exec, st_erase, st_div, st_reply, st_hang
  } fsm_type;

  typedef struct packed {
    fsm_type       state;
    logic          phase;
    logic          goto_hang;
    logic [15:0]   len;
    logic [15:0]   cnt;
    logic          first;
    logic [7:0]    opcode;
    logic [127:0]  key;
    logic [7:0]    sum;
    logic          sum_ok;
    logic          trail_ok;
    logic [7:0]    code;
    logic [7:0]    status;
    logic [2:0]    idx;
    logic          tx_valid;
    logic [7:0]    tx_data;
    logic          erase_start;
    logic [1:0]    stage;
    logic [5:0]    div_cnt;
    logic [47:0]   div_rem;
    logic [47:0]   div_quo;
    logic [31:0]   div_den;
    logic [31:0]   base;
    logic [7:0]    cand_divisor;
    logic          cand_half;
    logic [7:0]    divisor;
    logic [7:0]    duty;
    logic          mod_en;
    logic          half;
    logic [31:0]   clock_hz;
    logic [31:0]   limit;
    logic          waitreq;
    logic [31:0]   rdata;
  } core_type;

  core_type core_reg;
  core_type core_next;

  function automatic logic [7:0] reply_byte(input logic [2:0] i,
                                            input logic [7:0] c,
                                            input logic [7:0] s);
    case (i)
      3'h0:    reply_byte = REPLY_LEAD;
      3'h1:    reply_byte = LEN_HIGH;
      3'h2:    reply_byte = LEN_REPLY;
      3'h3:    reply_byte = c;
      3'h4:    reply_byte = s;
      3'h5:    reply_byte = 8'h00 - (LEN_HIGH + LEN_REPLY + c + s);
      default: reply_byte = TRAILER;
    endcase
  endfunction

  always_comb
  begin
    logic [47:0] rem_shift;
    logic [31:0] requested_bitrate;
    logic [31:0] ratio;
    logic [26:0] coarse;
    logic [13:0] den14;
    logic [7:0]  duty_c;
    logic [39:0] prod;
    logic [31:0] achieved;
    logic [31:0] diff;
    logic        len_ok;
    logic        is_key;
    rem_shift = 48'h0;
    requested_bitrate       = core_reg.key[31:0];
    ratio     = 32'h0;
    coarse    = 27'h0;
    den14     = 14'h0;
    duty_c    = 8'h00;
    prod      = 40'h0;
    achieved  = 32'h0;
    diff      = 32'h0;
    is_key    = (core_reg.opcode == OP_KEY);
    len_ok    = core_reg.len == {LEN_HIGH, is_key ? LEN_KEY : LEN_RATE};
    core_next = core_reg;
    core_next.erase_start = 1'b0;
    // avalon slave, one wait cycle per access
    core_next.waitreq = !((avs_read || avs_write) && core_reg.waitreq);
    if ((avs_read || avs_write) && core_reg.waitreq)
    begin
      case (avs_address)
        REG_STATUS:  core_next.rdata = {26'h0, core_reg.state == st_hang,
                       core_reg.mod_en, core_reg.half, PRESCALE_SEL,
                       core_reg.phase};
        REG_RATE:    core_next.rdata = {16'h0, core_reg.duty,
                       core_reg.divisor};
        REG_CLOCK:   core_next.rdata = core_reg.clock_hz;
        REG_LIMIT:   core_next.rdata = core_reg.limit;
        REG_OUTCOME: core_next.rdata = {16'h0, core_reg.code,
                       core_reg.status};
        default:     core_next.rdata = 32'h0;
      endcase
    end
    if (avs_write && !core_reg.waitreq)
    begin
      if (avs_address == REG_CLOCK)
        core_next.clock_hz = avs_writedata;
      if (avs_address == REG_LIMIT)
        core_next.limit = avs_writedata;
    end
    case (core_reg.state)
      st_lead:
        if (rx_valid && rx_data == CMD_LEAD)
          core_next.state = st_lenh;
      st_lenh:
        if (rx_valid)
        begin
          core_next.len[15:8] = rx_data;
          core_next.sum = rx_data;
          core_next.state = st_lenl;
        end
      st_lenl:
        if (rx_valid)
        begin
          core_next.len[7:0] = rx_data;
          core_next.cnt = {core_reg.len[15:8], rx_data};
          core_next.sum = core_reg.sum + rx_data;
          core_next.first = 1'b1;
          core_next.opcode = 8'h00;
          core_next.state = ({core_reg.len[15:8], rx_data} == 16'h0) ?
                            st_sum : st_body;
        end
      st_body:
        if (rx_valid)
        begin
          core_next.sum = core_reg.sum + rx_data;
          core_next.first = 1'b0;
          if (core_reg.first)
            core_next.opcode = rx_data;
          else
            core_next.key = {core_reg.key[119:0], rx_data};
          core_next.cnt = core_reg.cnt - 16'h1;
          if (core_reg.cnt == 16'h1)
            core_next.state = st_sum;
        end
      st_sum:
        if (rx_valid)
        begin
          core_next.sum_ok = (core_reg.sum + rx_data) == 8'h00;
          core_next.state = st_trail;
        end
      st_trail:
        if (rx_valid)
        begin
          core_next.trail_ok = (rx_data == TRAILER);
          core_next.state = st_exec;
        end
      st_exec:
      begin
        core_next.code = is_key ? REPLY_KEY_ERR : REPLY_RATE_ERR;
        core_next.goto_hang = 1'b0;
        core_next.state = st_reply;
        if (!is_key && core_reg.opcode != OP_RATE)
          core_next.state = st_lead;
        else if (!core_reg.trail_ok)
          core_next.status = ST_PACKET;
        else if (!core_reg.sum_ok)
          core_next.status = ST_CHECKSUM;
        else if (!len_ok)
          core_next.status = ST_PACKET;
        else if (is_key && core_reg.phase)
          core_next.status = ST_FLOW;
        else if (!is_key && !core_reg.phase)
          core_next.status = ST_FLOW;
        else if (is_key && !stored_id[127])
        begin
          core_next.status = ST_DISABLE;
          core_next.goto_hang = 1'b1;
        end
        else if (is_key && stored_id[126] &&
                 core_reg.key == MASS_ERASE_KEY)
        begin
          if (!access_window_lock_bit)
            core_next.status = ST_PROTECT;
          else
          begin
            core_next.erase_start = 1'b1;
            core_next.state = st_erase;
          end
        end
        else if (is_key)
        begin
          if (core_reg.key == stored_id)
          begin
            core_next.status = ST_OK;
            core_next.code = OP_KEY;
            core_next.phase = 1'b1;
          end
          else
          begin
            core_next.status = ST_MISMATCH;
            core_next.goto_hang = 1'b1;
          end
        end
        else if (requested_bitrate == 32'h0 || requested_bitrate > core_reg.limit)
          core_next.status = ST_MARGIN;
        else
        begin
          core_next.div_quo = {16'h0, core_reg.clock_hz};
          core_next.div_den = requested_bitrate;
          core_next.div_rem = 48'h0;
          core_next.div_cnt = 6'h0;
          core_next.stage = 2'h0;
          core_next.state = st_div;
        end
      end
      st_erase:
        if (erase_done)
        begin
          core_next.state = st_reply;
          if (erase_fault)
            core_next.status = ST_ERASE;
          else if (program_fault)
            core_next.status = ST_WRITE;
          else if (sequencer_fault)
            core_next.status = ST_SEQUENCER;
          else
          begin
            core_next.status = ST_OK;
            core_next.code = OP_KEY;
            core_next.phase = 1'b1;
          end
        end
      st_div:
        if (core_reg.div_cnt != DIV_STEPS)
        begin
          rem_shift = {core_reg.div_rem[46:0], core_reg.div_quo[47]};
          core_next.div_cnt = core_reg.div_cnt + 6'h1;
          if (rem_shift >= {16'h0, core_reg.div_den})
          begin
            core_next.div_rem = rem_shift - {16'h0, core_reg.div_den};
            core_next.div_quo = {core_reg.div_quo[46:0], 1'b1};
          end
          else
          begin
            core_next.div_rem = rem_shift;
            core_next.div_quo = {core_reg.div_quo[46:0], 1'b0};
          end
        end
        else
        begin
          core_next.div_rem = 48'h0;
          core_next.div_cnt = 6'h0;
          case (core_reg.stage)
            2'h0:
            begin
              ratio = core_reg.div_quo[31:0];
              coarse = ratio[31:5] - 27'h1;
              if (ratio < HALF_THRESHOLD)
              begin
                core_next.cand_half = 1'b1;
                core_next.cand_divisor = 8'h00;
                den14 = 14'h0010;
              end
              else
              begin
                core_next.cand_half = 1'b0;
                core_next.cand_divisor = (coarse > 27'hFF) ?
                                         DIVISOR_MAX : coarse[7:0];
                den14 = ({6'h0, core_next.cand_divisor} + 14'h1) << 5;
              end
              core_next.div_quo = {16'h0, core_reg.clock_hz};
              core_next.div_den = {18'h0, den14};
              core_next.stage = 2'h1;
            end
            2'h1:
            begin
              core_next.base = core_reg.div_quo[31:0];
              core_next.div_quo = {8'h00, requested_bitrate, 8'h00};
              core_next.div_den = core_reg.div_quo[31:0];
              core_next.stage = 2'h2;
            end
            default:
            begin
              core_next.state = st_reply;
              if (core_reg.div_quo > 48'hFF)
                achieved = core_reg.base;
              else
              begin
                duty_c = (core_reg.div_quo[7:0] < DUTY_MIN) ?
                         DUTY_MIN : core_reg.div_quo[7:0];
                prod = core_reg.base * {32'h0, duty_c};
                achieved = prod[39:8];
              end
              diff = (achieved > requested_bitrate) ? achieved - requested_bitrate : requested_bitrate - achieved;
              if ({5'h0, diff} * MARGIN_FACTOR > {5'h0, requested_bitrate})
                core_next.status = ST_MARGIN;
              else
              begin
                core_next.status = ST_OK;
                core_next.code = OP_RATE;
                core_next.divisor = core_reg.cand_divisor;
                core_next.half = core_reg.cand_half;
                core_next.mod_en = (core_reg.div_quo <= 48'hFF);
                core_next.duty = (core_reg.div_quo <= 48'hFF) ?
                                 duty_c : core_reg.duty;
              end
            end
          endcase
        end
      st_reply:
        if (!core_reg.tx_valid)
        begin
          core_next.tx_valid = 1'b1;
          core_next.idx = 3'h0;
          core_next.tx_data = reply_byte(3'h0, core_reg.code,
                                         core_reg.status);
        end
        else if (tx_ready)
        begin
          if (core_reg.idx == REPLY_LAST)
          begin
            core_next.tx_valid = 1'b0;
            core_next.state = core_reg.goto_hang ? st_hang : st_lead;
          end
          else
          begin
            core_next.idx = core_reg.idx + 3'h1;
            core_next.tx_data = reply_byte(core_reg.idx + 3'h1,
                                core_reg.code, core_reg.status);
          end
        end
      st_hang:
        core_next.state = st_hang;
      default:
        core_next.state = st_lead;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      core_reg          <= '0;
      core_reg.state    <= st_lead;
      core_reg.divisor  <= DIVISOR_RESET;
      core_reg.duty     <= DUTY_RESET;
      core_reg.clock_hz <= CLOCK_HZ_RESET;
      core_reg.limit    <= LIMIT_RESET;
      core_reg.waitreq  <= 1'b1;
    end
    else
      core_reg <= core_next;
  end

  assign avs_readdata           = core_reg.rdata;
  assign avs_waitrequest        = core_reg.waitreq;
  assign tx_valid               = core_reg.tx_valid;
  assign tx_data                = core_reg.tx_data;
  assign erase_start            = core_reg.erase_start;
  assign bit_rate_divisor       = core_reg.divisor;
  assign modulation_duty        = core_reg.duty;
  assign modulation_enable      = core_reg.mod_en;
  assign half_oversample_select = core_reg.half;
  assign prescale_select        = PRESCALE_SEL;
  assign command_phase          = core_reg.phase;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_HANG_STICKS: assert property (
    core_reg.state == st_hang |=> core_reg.state == st_hang)
    else $error("hang state left");
  AST_HANG_SILENT: assert property (
    core_reg.state == st_hang |-> !tx_valid && !erase_start)
    else $error("activity while hung");
  AST_REPLY_LEAD: assert property (
    $rose(tx_valid) |-> tx_data == REPLY_LEAD ##1 !$fell(tx_valid))
    else $error("reply does not open with lead byte");
  AST_REPLY_SUM: assert property (
    tx_valid && core_reg.idx == 3'h5 |->
    tx_data + core_reg.code + core_reg.status + LEN_REPLY == 8'h00)
    else $error("reply check byte wrong");
  AST_SETTINGS_HOLD: assert property (
    core_reg.state != st_div |=> $stable(bit_rate_divisor) &&
    $stable(modulation_duty) && $stable(half_oversample_select))
    else $error("uart settings changed outside bit rate command");
  AST_DUTY_FLOOR: assert property (
    modulation_enable && $changed(modulation_duty) |->
    modulation_duty >= DUTY_MIN)
    else $error("duty below floor");
  AST_ERASE_GUARD: assert property (
    erase_start |-> $past(access_window_lock_bit) &&
    $past(stored_id[127:126]) == 2'b11)
    else $error("erase started without permission");
  AST_FLOW_KEY: assert property (
    core_reg.state == st_exec && core_reg.opcode == OP_KEY &&
    core_reg.phase && core_reg.trail_ok && core_reg.sum_ok &&
    core_reg.len == {LEN_HIGH, LEN_KEY} |=>
    core_reg.status == ST_FLOW && core_reg.code == REPLY_KEY_ERR)
    else $error("key check in command phase not refused");
  AST_MISMATCH_HANG: assert property (
    $rose(tx_valid) && core_reg.status == ST_MISMATCH |->
    core_reg.goto_hang)
    else $error("mismatch does not lead to hang");
  AST_PHASE_KEEP: assert property (
    command_phase |=> command_phase)
    else $error("command phase lost");

  COV_KEY_OK: cover property (
    $rose(command_phase) && core_reg.code == OP_KEY);
  COV_ERASE: cover property (erase_start ##[1:200] erase_done);
  COV_RATE_OK: cover property ($changed(bit_rate_divisor));
  COV_HANG: cover property ($rose(core_reg.state == st_hang));

endmodule

// [src/boot_cmd_pkg.sv]
// constants for the key check and bit rate command handler
package boot_cmd_pkg;
  localparam logic [7:0]   CMD_LEAD        = 8'h01;
  localparam logic [7:0]   REPLY_LEAD      = 8'h81;
  localparam logic [7:0]   TRAILER         = 8'h03;
  localparam logic [7:0]   OP_KEY          = 8'h30;
  localparam logic [7:0]   OP_RATE         = 8'h34;
  localparam logic [7:0]   LEN_HIGH        = 8'h00;
  localparam logic [7:0]   LEN_KEY         = 8'h11;
  localparam logic [7:0]   LEN_RATE        = 8'h05;
  localparam logic [7:0]   LEN_REPLY       = 8'h02;
  localparam logic [7:0]   REPLY_KEY_ERR   = 8'hB0;
  localparam logic [7:0]   REPLY_RATE_ERR  = 8'hB4;
  localparam logic [7:0]   ST_OK           = 8'h00;
  localparam logic [7:0]   ST_PACKET       = 8'hC1;
  localparam logic [7:0]   ST_CHECKSUM     = 8'hC2;
  localparam logic [7:0]   ST_FLOW         = 8'hC3;
  localparam logic [7:0]   ST_MARGIN       = 8'hD4;
  localparam logic [7:0]   ST_PROTECT      = 8'hDA;
  localparam logic [7:0]   ST_MISMATCH     = 8'hDB;
  localparam logic [7:0]   ST_DISABLE      = 8'hDC;
  localparam logic [7:0]   ST_ERASE        = 8'hE1;
  localparam logic [7:0]   ST_WRITE        = 8'hE2;
  localparam logic [7:0]   ST_SEQUENCER    = 8'hE7;
  localparam logic [127:0] MASS_ERASE_KEY  =
    128'h414C6552_415345FF_FFFFFFFF_FFFFFFFF;
  localparam logic [31:0]  HALF_THRESHOLD  = 32'h0000_0020;
  localparam logic [7:0]   DIVISOR_MAX     = 8'hFF;
  localparam logic [7:0]   DUTY_MIN        = 8'h80;
  localparam logic [1:0]   PRESCALE_SEL    = 2'h0;
  localparam logic [36:0]  MARGIN_FACTOR   = 37'h00_0000_0019;
  localparam logic [5:0]   DIV_STEPS       = 6'h30;
  localparam logic [2:0]   REPLY_LAST      = 3'h6;
  localparam logic [4:0]   REG_STATUS      = 5'h00;
  localparam logic [4:0]   REG_RATE        = 5'h04;
  localparam logic [4:0]   REG_CLOCK       = 5'h08;
  localparam logic [4:0]   REG_LIMIT       = 5'h0C;
  localparam logic [4:0]   REG_OUTCOME     = 5'h10;
  localparam logic [7:0]   DIVISOR_RESET   = 8'hFF;
  localparam logic [7:0]   DUTY_RESET      = 8'hFF;
  localparam logic [31:0]  CLOCK_HZ_RESET  = 32'h02FA_F080;
  localparam logic [31:0]  LIMIT_RESET     = 32'h001E_8480;
endpackage
